//--- rtl/stage_routing_regs.svh
// Offsets, field positions and reset values of the stage routing word.
// Assumes inclusion by bare name from the design modules.
`ifndef STAGE_ROUTING_REGS_SVH
`define STAGE_ROUTING_REGS_SVH

// Printed word indices; byte address is four times the index
`define UPPER_ROUTING_IDX_BASE 12'h081
`define UPPER_ROUTING_IDX_STRIDE 12'h008
`define STAGE_COUNT 12
`define ROUTING_FIELD_W 2
`define ROUTING_FIELD_COUNT 6
`define MEAS_TYPE_LSB 12
`define NEG_OFFSET_OFF_BIT 14
`define POS_OFFSET_OFF_BIT 15
`define ROUTING_WORD_W 16
`define ROUTING_WORD_RESET 16'h0000
`define OFFSET_STEP_FF 320

`endif

//--- rtl/stage_routing_pkg.sv
// Types for the stage upper-input routing registers.
// Assumes stage_routing_regs.svh for the numeric constants.
package stage_routing_pkg;

    typedef enum logic [1:0] {
        ROUTE_OPEN = 2'b00,
        ROUTE_NEG = 2'b01,
        ROUTE_POS = 2'b10,
        ROUTE_BIAS = 2'b11
    } route_code_e;

    typedef enum logic [1:0] {
        MEAS_ILLEGAL = 2'b00,
        MEAS_SE_POS = 2'b01,
        MEAS_SE_NEG = 2'b10,
        MEAS_DIFF = 2'b11
    } meas_type_e;

    typedef enum {
        WR_IDLE,
        WR_RESP
    } wr_state_e;

    typedef enum {
        RD_IDLE,
        RD_RESP
    } rd_state_e;

endpackage : stage_routing_pkg

//--- rtl/input_route_decode.sv
// Decodes one stage routing word into per-input switch controls.
// Assumes a stable stored word; purely combinational.
`timescale 1ns/1ps
`include "stage_routing_regs.svh"

module input_route_decode
    import stage_routing_pkg::*;
#(
    parameter int NUM_INPUTS = `ROUTING_FIELD_COUNT
) (
    input wire logic [15:0] word, // Stored routing word
    output logic [NUM_INPUTS-1:0] to_neg, // Input on converter negative
    output logic [NUM_INPUTS-1:0] to_pos, // Input on converter positive
    output logic [NUM_INPUTS-1:0] to_bias, // Input tied to bias
    output logic differential, // Differential measurement
    output logic neg_offset_en, // Negative offset injection on
    output logic pos_offset_en // Positive offset injection on
);

    function automatic route_code_e field_code(input logic [15:0] w,
                                                input int idx);
        field_code = route_code_e'(w[idx*`ROUTING_FIELD_W +: 2]);
    endfunction : field_code

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
            // Open (00) drives no switch
            assign to_neg[gi] = field_code(word, gi) == ROUTE_NEG;
            assign to_pos[gi] = field_code(word, gi) == ROUTE_POS;
            assign to_bias[gi] = field_code(word, gi) == ROUTE_BIAS;
        end
    endgenerate

    assign differential =
        meas_type_e'(word[`MEAS_TYPE_LSB +: 2]) == MEAS_DIFF;
    assign neg_offset_en = !word[`NEG_OFFSET_OFF_BIT];
    assign pos_offset_en = !word[`POS_OFFSET_OFF_BIT];

endmodule : input_route_decode

//--- rtl/stage_upper_input_routing_config.sv
// AXI4-Lite register bank of per-stage upper-input routing words.
// Assumes one AXI4-Lite master; the sequencer supplies the active stage.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "stage_routing_regs.svh"

// Function
// - Code 00 leaves input open; input 7 bits [1:0]
// - Code 01 connects input to converter negative
// - Code 10 connects input to converter positive
// - Code 11 ties input to bias
// - Input 8 field at bits [3:2]
// - Input 9 field at bits [5:4]
// - Input 10 field at bits [7:6]
// - Input 11 field at bits [9:8]
// - Input 12 field at bits [11:10]
// - Measurement type 11 selects differential
// - Bit 14 set disables negative offset
// - Bit 15 set disables positive offset
// - One word per stage, stride eight words
// - Offset magnitude held elsewhere, 0.32 pF steps
module stage_upper_input_routing_config
    import stage_routing_pkg::*;
#(
    parameter int NUM_STAGES = `STAGE_COUNT,
    parameter int ADDR_W = 12
) (
    input wire logic aclk, // Clock, 125 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, ignored
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, ignored
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [3:0] active_stage, // Stage being converted
    output logic [5:0] sensor_input_to_neg, // Inputs 7..12 on negative
    output logic [5:0] sensor_input_to_pos, // Inputs 7..12 on positive
    output logic [5:0] sensor_input_to_bias, // Inputs 7..12 on bias
    output logic differential_mode, // Differential measurement
    output logic negative_offset_en, // Negative offset injection on
    output logic positive_offset_en // Positive offset injection on
);

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Stage index for a byte address, or -1 when unmapped
    function automatic int stage_of(input logic [ADDR_W-1:0] addr);
        int idx;
        int off;
        idx = int'(addr >> 2);
        stage_of = -1;
        off = idx - `UPPER_ROUTING_IDX_BASE;
        if (addr[1:0] == 2'b00 && off >= 0 &&
            off % `UPPER_ROUTING_IDX_STRIDE == 0 &&
            off / `UPPER_ROUTING_IDX_STRIDE < NUM_STAGES) begin
            stage_of = off / `UPPER_ROUTING_IDX_STRIDE;
        end
    endfunction : stage_of

    logic [15:0] word_r [NUM_STAGES];
    logic [15:0] word_nxt [NUM_STAGES];

    wr_state_e wr_state_r;
    wr_state_e wr_state_nxt;
    logic aw_held_r;
    logic aw_held_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [ADDR_W-1:0] awaddr_r;
    logic [ADDR_W-1:0] awaddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    rd_state_e rd_state_r;
    rd_state_e rd_state_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    logic [15:0] active_word;
    logic [5:0] dec_neg;
    logic [5:0] dec_pos;
    logic [5:0] dec_bias;
    logic dec_diff;
    logic dec_neg_en;
    logic dec_pos_en;
    logic [5:0] to_neg_r;
    logic [5:0] to_neg_nxt;
    logic [5:0] to_pos_r;
    logic [5:0] to_pos_nxt;
    logic [5:0] to_bias_r;
    logic [5:0] to_bias_nxt;
    logic diff_r;
    logic diff_nxt;
    logic neg_en_r;
    logic neg_en_nxt;
    logic pos_en_r;
    logic pos_en_nxt;

    // Write channel: address and data taken in either order
    always_comb begin
        logic [ADDR_W-1:0] a;
        logic [31:0] d;
        logic [3:0] s;
        int st;
        a = '0;
        d = '0;
        s = '0;
        st = -1;
        wr_state_nxt = wr_state_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bresp_nxt = bresp_r;
        word_nxt = word_r;
        s_axi_awready = wr_state_r == WR_IDLE && !aw_held_r;
        s_axi_wready = wr_state_r == WR_IDLE && !w_held_r;
        unique case (wr_state_r)
            WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                if (aw_held_nxt && w_held_nxt) begin
                    a = aw_held_r ? awaddr_r : s_axi_awaddr;
                    d = w_held_r ? wdata_r : s_axi_wdata;
                    s = w_held_r ? wstrb_r : s_axi_wstrb;
                    st = stage_of(a);
                    if (st >= 0) begin
                        // Low 16 bits stored as written, each byte only when its strobe is set
                        if (s[0]) begin
                            word_nxt[st][7:0] = d[7:0];
                        end
                        if (s[1]) begin
                            word_nxt[st][15:8] = d[15:8];
                        end
                        bresp_nxt = RESP_OKAY;
                    end else begin
                        bresp_nxt = RESP_SLVERR;
                    end
                    aw_held_nxt = 1'b0;
                    w_held_nxt = 1'b0;
                    wr_state_nxt = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_nxt = WR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= WR_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bresp_r <= RESP_OKAY;
            for (int i = 0; i < NUM_STAGES; i++) begin
                word_r[i] <= `ROUTING_WORD_RESET;
            end
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
            word_r <= word_nxt;
        end
    end

    assign s_axi_bvalid = wr_state_r == WR_RESP;
    assign s_axi_bresp = bresp_r;

    // Read channel: one read under way at a time
    always_comb begin
        int st;
        st = -1;
        rd_state_nxt = rd_state_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        s_axi_arready = rd_state_r == RD_IDLE;
        unique case (rd_state_r)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    st = stage_of(s_axi_araddr);
                    if (st >= 0) begin
                        rdata_nxt = {16'h0000, word_r[st]};
                        rresp_nxt = RESP_OKAY;
                    end else begin
                        rdata_nxt = 32'h0000_0000;
                        rresp_nxt = RESP_SLVERR;
                    end
                    rd_state_nxt = RD_RESP;
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_nxt = RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= RD_IDLE;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_rvalid = rd_state_r == RD_RESP;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Word of the stage under conversion; out-of-range reads as open
    always_comb begin
        active_word = `ROUTING_WORD_RESET;
        if (int'(active_stage) < NUM_STAGES) begin
            active_word = word_r[active_stage];
        end
    end

    // Fields: input 7 at [1:0] through input 12 at [11:10]
    input_route_decode #(
        .NUM_INPUTS(`ROUTING_FIELD_COUNT)
    ) u_decode (
        .word(active_word),
        .to_neg(dec_neg),
        .to_pos(dec_pos),
        .to_bias(dec_bias),
        .differential(dec_diff),
        // Enables only; the offset magnitude sits in another register
        .neg_offset_en(dec_neg_en),
        .pos_offset_en(dec_pos_en)
    );

    // Switch controls held in flops so the pins see no decode glitches
    always_comb begin
        to_neg_nxt = dec_neg;
        to_pos_nxt = dec_pos;
        to_bias_nxt = dec_bias;
        diff_nxt = dec_diff;
        neg_en_nxt = dec_neg_en;
        pos_en_nxt = dec_pos_en;
    end

    // Reset values match the decode of the all-zero reset word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_neg_r <= '0;
            to_pos_r <= '0;
            to_bias_r <= '0;
            diff_r <= 1'b0;
            neg_en_r <= 1'b1;
            pos_en_r <= 1'b1;
        end else begin
            to_neg_r <= to_neg_nxt;
            to_pos_r <= to_pos_nxt;
            to_bias_r <= to_bias_nxt;
            diff_r <= diff_nxt;
            neg_en_r <= neg_en_nxt;
            pos_en_r <= pos_en_nxt;
        end
    end

    assign sensor_input_to_neg = to_neg_r;
    assign sensor_input_to_pos = to_pos_r;
    assign sensor_input_to_bias = to_bias_r;
    assign differential_mode = diff_r;
    assign negative_offset_en = neg_en_r;
    assign positive_offset_en = pos_en_r;

endmodule : stage_upper_input_routing_config

//--- sim/stage_routing_checker.sv
// Concurrent checks on the routing bank's bus and decode ports.
// Assumes a bind into the top module; sees its ports only.
`timescale 1ns/1ps
module stage_routing_checker #(
    parameter int NUM_STAGES = 12
) (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic s_axi_rready, differential_mode,
    input wire logic negative_offset_en, positive_offset_en,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0] active_stage,
    input wire logic [5:0] sensor_input_to_neg, sensor_input_to_pos,
    input wire logic [5:0] sensor_input_to_bias
);
    logic [20:0] outs;
    assign outs = {sensor_input_to_neg, sensor_input_to_pos,
        sensor_input_to_bias, differential_mode, negative_offset_en,
        positive_offset_en};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    code_excl_a: assert property (((sensor_input_to_neg &
        sensor_input_to_pos) | ((sensor_input_to_neg | sensor_input_to_pos)
        & sensor_input_to_bias)) == 6'h00) else $error("two routes");
    stage_range_a: assert property (active_stage >= NUM_STAGES
        |=> outs == 21'h000003) else $error("idle stage not clear");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("no write response");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read response");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    r_upper_a: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    read_quiet_a: assert property (!s_axi_awvalid && !s_axi_wvalid
        ##1 $stable(active_stage) |=> $stable(outs))
        else $error("decode moved without write");
endmodule : stage_routing_checker

bind stage_upper_input_routing_config stage_routing_checker
    #(.NUM_STAGES(NUM_STAGES)) chk_u (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .differential_mode, .negative_offset_en,
    .positive_offset_en, .s_axi_bresp, .s_axi_rdata, .active_stage,
    .sensor_input_to_neg, .sensor_input_to_pos, .sensor_input_to_bias);

//--- sim/test_stage_upper_input_routing_config.sv
// Bench for the routing bank: AXI4-Lite traffic, read-back and decode.
// Assumes twelve stages and a single 125 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module test_stage_upper_input_routing_config;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic awr, wrd, arr, bv, rv, dm, ne, pe;
    logic [1:0] br, rr, eb;
    logic [31:0] wd = 0, rdat;
    logic [11:0] awa = 0, ara = 0;
    logic [3:0] ws = 0, stg = 0;
    logic [2:0] prot = 0;
    logic [5:0] tn, tp, tb;
    logic [33:0] er;
    logic [15:0] mem[12], cw;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int failures = 0, n_tests = 0;
    stage_upper_input_routing_config dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awprot(prot), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(prot),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .active_stage(stg), .sensor_input_to_neg(tn),
        .sensor_input_to_pos(tp), .sensor_input_to_bias(tb),
        .differential_mode(dm), .negative_offset_en(ne),
        .positive_offset_en(pe));
    always #4 aclk = ~aclk;
    function automatic logic [11:0] addr_of(input int s);
        return 12'h204 + 12'(s) * 12'h020;
    endfunction : addr_of
    function automatic logic [20:0] dec(input logic [15:0] w);
        logic [5:0] n, p, b;
        for (int i = 0; i < 6; i++) begin
            n[i] = w[2*i+:2] == 2'b01;
            p[i] = w[2*i+:2] == 2'b10;
            b[i] = w[2*i+:2] == 2'b11;
        end
        return {n, p, b, w[13:12] == 2'b11, !w[14], !w[15]};
    endfunction : dec
    task automatic chk(input logic [3:0] s, input logic [15:0] w);
        @(posedge aclk);
        stg <= s;
        @(posedge aclk);
        @(negedge aclk);
        `CHK({tn, tp, tb, dm, ne, pe}, dec(w))
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] r);
        logic ad, dd;
        ad = 0;
        dd = 0;
        bq.push_back(r);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad |= awv && awr;
            dd |= wv && wrd;
            if (ad) awv <= 1'b0;
            if (dd) wv <= 1'b0;
        end
        do begin
            @(posedge aclk);
            if (!bry) bry <= 1'($urandom);
        end while (!(bv && bry));
        bry <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] d,
        input logic [1:0] r);
        rq.push_back({r, 16'h0000, d});
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do begin
            @(posedge aclk);
            if (!rry) rry <= 1'($urandom);
        end while (!(rv && rry));
        rry <= 1'b0;
    endtask : rd
    always @(posedge aclk) begin
        if (bv && bry) begin
            eb = bq.pop_front();
            `CHK(br, eb)
        end
        if (rv && rry) begin
            er = rq.pop_front();
            `CHK({rr, rdat}, er)
        end
    end
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        failures++;
        test_done;
    end
    initial begin
        void'($urandom(32'h7d1ee8e3));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk(4'd0, 16'h0000);
        // Every code in every field, offsets toggled, differential;
        // then one single-ended word for each converter side
        for (int c = 0; c < 6; c++) begin
            cw = c < 4 ? {c[0], c[1], 2'b11, {6{2'(c)}}} :
                (c == 4 ? 16'h1ffe : 16'he7ff);
            wr(12'h204, {16'hffff, cw}, 4'b0011, 2'b00);
            chk(4'd0, cw);
        end
        for (int s = 0; s < 12; s++) begin
            mem[s] = 16'($urandom) | 16'h3000;
            wr(addr_of(s), {16'($urandom), mem[s]}, 4'hf, 2'b00);
        end
        for (int s = 0; s < 12; s++) begin
            rd(addr_of(s), mem[s], 2'b00);
            chk(4'(s), mem[s]);
        end
        for (int s = 12; s < 16; s++) chk(4'(s), 16'h0000);
        // Byte lanes write one half each
        wr(addr_of(3), 32'h0000a5a5, 4'b0001, 2'b00);
        mem[3][7:0] = 8'ha5;
        wr(addr_of(3), 32'h00005a5a, 4'b0010, 2'b00);
        mem[3][15:8] = 8'h5a;
        rd(addr_of(3), mem[3], 2'b00);
        // Neighbour word, misaligned, past last stage
        foreach (mem[i]) if (i < 3) begin
            cw = i == 0 ? 16'h0208 : (i == 1 ? 16'h0205 : 16'h0384);
            wr(cw[11:0], 32'h0000ffff, 4'hf, 2'b10);
            rd(cw[11:0], 16'h0000, 2'b10);
        end
        rd(addr_of(0), mem[0], 2'b00);
        test_done;
    end
endmodule : test_stage_upper_input_routing_config
